//--- design/tmrcc_defs.vh
// Purpose: constants for the 16-bit capture/compare timer control block
// Assumes: registers sit at byte address four times their index
// Notes:   definitions only
`ifndef TMRCC_DEFS_VH
`define TMRCC_DEFS_VH

// register indices (byte address = index * 4)
`define TMRCC_IDX_CTRL2       6'h31
`define TMRCC_IDX_CTRL1       6'h32
`define TMRCC_IDX_STATUS      6'h33
`define TMRCC_IDX_CAPA_HI     6'h34
`define TMRCC_IDX_CAPA_LO     6'h35
`define TMRCC_IDX_CMPA_HI     6'h36
`define TMRCC_IDX_CMPA_LO     6'h37
`define TMRCC_IDX_CNT_HI      6'h38
`define TMRCC_IDX_CNT_LO      6'h39
`define TMRCC_IDX_ACNT_HI     6'h3a
`define TMRCC_IDX_ACNT_LO     6'h3b
`define TMRCC_IDX_CAPB_HI     6'h3c
`define TMRCC_IDX_CAPB_LO     6'h3d
`define TMRCC_IDX_CMPB_HI     6'h3e
`define TMRCC_IDX_CMPB_LO     6'h3f

// timer_control_one fields
`define TMRCC_C1_CAP_IE       7
`define TMRCC_C1_CMP_IE       6
`define TMRCC_C1_OVF_IE       5
`define TMRCC_C1_FORCE_B      4
`define TMRCC_C1_FORCE_A      3
`define TMRCC_C1_LEVEL_B      2
`define TMRCC_C1_CAPA_EDGE    1
`define TMRCC_C1_LEVEL_A      0

// timer_control_two fields
`define TMRCC_C2_PIN_A_EN     7
`define TMRCC_C2_PIN_B_EN     6
`define TMRCC_C2_ONE_PULSE    5
`define TMRCC_C2_PWM          4
`define TMRCC_C2_CLK_HI       3
`define TMRCC_C2_CLK_LO       2
`define TMRCC_C2_CAPB_EDGE    1
`define TMRCC_C2_EXT_EDGE     0

// status: flags in bits 7..3, freeze in bit 2; flag vector index
`define TMRCC_ST_FREEZE       2
`define TMRCC_FL_CAPA         4
`define TMRCC_FL_CMPA         3
`define TMRCC_FL_OVF          2
`define TMRCC_FL_CAPB         1
`define TMRCC_FL_CMPB         0

// clock select codes and prescaler terminal counts
`define TMRCC_CS_DIV4         2'b00
`define TMRCC_CS_DIV2         2'b01
`define TMRCC_CS_DIV8         2'b10
`define TMRCC_CS_EXT          2'b11
`define TMRCC_PRE_DIV2        3'h1
`define TMRCC_PRE_DIV4        3'h3
`define TMRCC_PRE_DIV8        3'h7
`define TMRCC_EXT_CLK_AVAIL   1'b1

// reset and load values
`define TMRCC_CTRL_RST        8'h00
`define TMRCC_CNT_RST         16'hfffc
`define TMRCC_CNT_MAX         16'hffff
`define TMRCC_OPM_CAP         16'hfffd
`define TMRCC_CMP_RST         16'h8000

// bus answers
`define TMRCC_RESP_OKAY       2'b00
`define TMRCC_RESP_SLVERR     2'b10
`endif

//--- design/tmrcc_top.v
// Purpose: 16-bit timer with two captures, two compares, one-pulse and pwm modes
// Assumes: aclk is the cpu clock; halt_mode and wait_mode come from the core
// Notes:   registers reached over axi4-lite, one 8-bit register per word
//
// Contract
// - in wait the timer runs unchanged; any enabled timer interrupt wakes the device
// - halt freezes registers and counter; interrupt wake resumes, reset restarts counter
// - capture edge during halt arms; interrupt wake sets flag, captures exit count
// - pwm mode makes no compare events; first capture flag marks each period end
// - one shared interrupt: flag and enable set and global mask clear
// - control one bit 7 enables interrupt from either capture flag
// - control one bit 6 enables interrupt from either compare flag
// - control one bit 5 enables interrupt from the overflow flag
// - force bit b copies level b onto compare pin b without a match, outside one-pulse and pwm modes
// - force bit a copies level a onto compare pin a without a match, outside one-pulse and pwm modes
// - level b goes to pin b on compare b match; pin a in pulse modes
// - control one bit 1 picks capture a edge: 0 falling, 1 rising
// - level a goes to pin a on each compare a match when enabled
// - control two bit 7 only routes the compare a signal to its pin
// - control two bit 6 only routes the compare b signal to its pin
// - one-pulse mode fires one pulse at capture a edge, length from compare a
// - pwm mode repeats a waveform: pulse from compare a, period from compare b
// - clock select: 00 divide 4, 01 divide 2, 10 divide 8, 11 external
// - external clock select with no external pin leaves the counter stopped
// - control two bit 1 picks capture b edge: 0 falling, 1 rising
// - control two bit 0 picks external clock edge: 0 falling, 1 rising
// - three control/status registers plus six 16-bit data register pairs
// - flag clears after status read while set, then low data byte access
// - writing counter low or alternate counter low resets the counter
// - with one-pulse and pwm both set, only pwm acts
`timescale 1ns/1ns
`default_nettype none
`include "tmrcc_defs.vh"

module tmrcc_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // axi4-lite write response
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  // axi4-lite read
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  // pins from outside
  input  wire        capture_a_pin,
  input  wire        capture_b_pin,
  input  wire        ext_count_clock_pin,
  // compare pins
  output wire        compare_a_pin,
  output wire        compare_a_oe,
  output wire        compare_b_pin,
  output wire        compare_b_oe,
  // core side
  input  wire        global_irq_mask,
  input  wire        wait_mode,
  input  wire        halt_mode,
  output wire        timer_irq,
  output wire        wait_wake
);

  // registers
  reg  [7:0]  ctrl1_q;
  reg  [7:0]  ctrl2_q;
  reg         freeze_q;
  reg  [15:0] cnt_q;
  reg  [2:0]  presc_q;
  reg  [15:0] capa_q;
  reg  [15:0] capb_q;
  reg  [15:0] cmpa_q;
  reg  [15:0] cmpb_q;
  reg  [4:0]  flag_q;
  reg  [4:0]  seen_q;
  reg  [1:0]  armed_q;
  reg         halt_q;
  reg         out_a_q;
  reg         out_b_q;
  reg         pin_a_q;
  reg         pin_b_q;
  reg         oe_a_q;
  reg         oe_b_q;
  reg         irq_q;
  reg         wake_q;
  reg  [2:0]  sync1_q;
  reg  [2:0]  sync2_q;
  reg  [2:0]  sync3_q;
  reg  [2:0]  lvl_q;
  // bus registers
  reg         awready_q;
  reg         wready_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg  [5:0]  waddr_q;
  reg  [7:0]  wbyte_q;
  reg         wlane_q;
  reg         arready_q;
  reg         rvalid_q;
  reg  [1:0]  rresp_q;
  reg  [7:0]  rbyte_q;

  // combinational signals
  wire [2:0]  pin_raw;
  wire [2:0]  rise;
  wire [2:0]  fall;
  wire        pwm_on;
  wire        opm_on;
  wire        run;
  wire        wr_go;
  wire        rd_go;
  wire [5:0]  ridx;
  wire        capa_edge;
  wire        capb_edge;
  wire        ext_edge;
  wire        halt_exit;
  wire [1:0]  cs;
  wire        cmpa_hit;
  wire        cmpb_hit;
  wire        cnt_clear;
  wire        opm_fire;
  wire        irq_src;
  reg         tick;
  reg  [4:0]  low_acc;
  reg  [4:0]  set_v;
  reg  [7:0]  rd_d;
  reg         rd_ok;
  reg  [15:0] cnt_d;
  reg         out_a_d;
  reg         out_b_d;

  assign pin_raw = {ext_count_clock_pin, capture_b_pin, capture_a_pin};

  // three-stage sync; settled level only moves once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          sync3_q[gi] <= 1'b0;
          lvl_q[gi]   <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            lvl_q[gi] <= sync2_q[gi];
          end
        end
      end
      assign rise[gi] = (sync2_q[gi] == sync3_q[gi]) & sync2_q[gi] & ~lvl_q[gi];
      assign fall[gi] = (sync2_q[gi] == sync3_q[gi]) & ~sync2_q[gi] & lvl_q[gi];
    end
  endgenerate

  // edge selection per input
  assign capa_edge = ctrl1_q[`TMRCC_C1_CAPA_EDGE] ? rise[0] : fall[0];
  assign capb_edge = ctrl2_q[`TMRCC_C2_CAPB_EDGE] ? rise[1] : fall[1];
  assign ext_edge  = ctrl2_q[`TMRCC_C2_EXT_EDGE] ? rise[2] : fall[2];

  // mode decode; pwm overrides one-pulse
  assign pwm_on = ctrl2_q[`TMRCC_C2_PWM];
  assign opm_on = ctrl2_q[`TMRCC_C2_ONE_PULSE] & ~pwm_on;
  // halt stops counting, compares and captures; wait has no effect on the timer
  assign run       = ~halt_mode & ~freeze_q;
  assign halt_exit = halt_q & ~halt_mode;
  assign cs        = {ctrl2_q[`TMRCC_C2_CLK_HI], ctrl2_q[`TMRCC_C2_CLK_LO]};

  // timer tick from prescaler or external pin
  always @* begin
    case (cs)
      `TMRCC_CS_DIV4: tick = ({1'b0, presc_q[1:0]} == `TMRCC_PRE_DIV4);
      `TMRCC_CS_DIV2: tick = ({2'b00, presc_q[0]} == `TMRCC_PRE_DIV2);
      `TMRCC_CS_DIV8: tick = (presc_q == `TMRCC_PRE_DIV8);
      default:        tick = ext_edge & `TMRCC_EXT_CLK_AVAIL;
    endcase
  end

  // compare matches only on a counting tick
  assign cmpa_hit  = run & tick & (cnt_q == cmpa_q);
  assign cmpb_hit  = run & tick & (cnt_q == cmpb_q);
  assign opm_fire  = run & opm_on & capa_edge;
  assign wr_go     = ~awready_q & ~wready_q & ~bvalid_q;
  assign rd_go     = arvalid & arready_q;
  assign ridx      = araddr[7:2];
  assign cnt_clear = wr_go & ((waddr_q == `TMRCC_IDX_CNT_LO) |
                     (waddr_q == `TMRCC_IDX_ACNT_LO));

  // low-byte accesses that may clear a flag, by read or by write
  always @* begin
    low_acc = 5'b0_0000;
    if (rd_go) begin
      low_acc[`TMRCC_FL_CAPA] = (ridx == `TMRCC_IDX_CAPA_LO);
      low_acc[`TMRCC_FL_CMPA] = (ridx == `TMRCC_IDX_CMPA_LO);
      low_acc[`TMRCC_FL_OVF]  = (ridx == `TMRCC_IDX_CNT_LO);
      low_acc[`TMRCC_FL_CAPB] = (ridx == `TMRCC_IDX_CAPB_LO);
      low_acc[`TMRCC_FL_CMPB] = (ridx == `TMRCC_IDX_CMPB_LO);
    end
    if (wr_go) begin
      low_acc[`TMRCC_FL_CAPA] = low_acc[`TMRCC_FL_CAPA] | (waddr_q == `TMRCC_IDX_CAPA_LO);
      low_acc[`TMRCC_FL_CMPA] = low_acc[`TMRCC_FL_CMPA] | (waddr_q == `TMRCC_IDX_CMPA_LO);
      low_acc[`TMRCC_FL_OVF]  = low_acc[`TMRCC_FL_OVF] | (waddr_q == `TMRCC_IDX_CNT_LO);
      low_acc[`TMRCC_FL_CAPB] = low_acc[`TMRCC_FL_CAPB] | (waddr_q == `TMRCC_IDX_CAPB_LO);
      low_acc[`TMRCC_FL_CMPB] = low_acc[`TMRCC_FL_CMPB] | (waddr_q == `TMRCC_IDX_CMPB_LO);
    end
  end

  // flag set sources and counter next value
  always @* begin
    set_v = 5'b0_0000;
    cnt_d = cnt_q;
    if (run) begin
      if (pwm_on) begin
        set_v[`TMRCC_FL_CAPA] = cmpb_hit;
        set_v[`TMRCC_FL_CAPB] = capb_edge;
      end else if (opm_on) begin
        set_v[`TMRCC_FL_CAPA] = opm_fire;
        set_v[`TMRCC_FL_CMPB] = cmpb_hit; // compare b still times out
        set_v[`TMRCC_FL_CAPB] = capb_edge;
      end else begin
        set_v[`TMRCC_FL_CAPA] = capa_edge;
        set_v[`TMRCC_FL_CAPB] = capb_edge;
        set_v[`TMRCC_FL_CMPA] = cmpa_hit & ~ctrl1_q[`TMRCC_C1_FORCE_A];
        set_v[`TMRCC_FL_CMPB] = cmpb_hit & ~ctrl1_q[`TMRCC_C1_FORCE_B];
      end
      if (tick) begin
        cnt_d = cnt_q + 16'h0001;
        set_v[`TMRCC_FL_OVF] = (cnt_q == `TMRCC_CNT_MAX);
      end
      if (opm_fire | (pwm_on & cmpb_hit)) begin
        cnt_d = `TMRCC_CNT_RST;
      end
    end
    if (halt_exit) begin
      set_v[`TMRCC_FL_CAPA] = set_v[`TMRCC_FL_CAPA] | armed_q[0];
      set_v[`TMRCC_FL_CAPB] = set_v[`TMRCC_FL_CAPB] | armed_q[1];
    end
    if (cnt_clear) begin
      cnt_d = `TMRCC_CNT_RST;
    end
  end

  // compare output latches
  always @* begin
    out_a_d = out_a_q;
    out_b_d = out_b_q;
    if (run & (pwm_on | opm_on)) begin
      if (opm_fire | (pwm_on & cmpb_hit)) begin
        out_a_d = ctrl1_q[`TMRCC_C1_LEVEL_B];
      end else if (cmpa_hit) begin
        out_a_d = ctrl1_q[`TMRCC_C1_LEVEL_A];
      end
    end else if (run) begin
      if (ctrl1_q[`TMRCC_C1_FORCE_A] | cmpa_hit) begin
        out_a_d = ctrl1_q[`TMRCC_C1_LEVEL_A];
      end
      if (ctrl1_q[`TMRCC_C1_FORCE_B] | cmpb_hit) begin
        out_b_d = ctrl1_q[`TMRCC_C1_LEVEL_B];
      end
    end
  end

  // read mux; unmapped index answers with an error
  always @* begin
    rd_ok = 1'b1;
    case (ridx)
      `TMRCC_IDX_CTRL2:    rd_d = ctrl2_q;
      `TMRCC_IDX_CTRL1:    rd_d = ctrl1_q;
      `TMRCC_IDX_STATUS:   rd_d = {flag_q, freeze_q, 2'b00};
      `TMRCC_IDX_CAPA_HI:  rd_d = capa_q[15:8];
      `TMRCC_IDX_CAPA_LO:  rd_d = capa_q[7:0];
      `TMRCC_IDX_CMPA_HI:  rd_d = cmpa_q[15:8];
      `TMRCC_IDX_CMPA_LO:  rd_d = cmpa_q[7:0];
      `TMRCC_IDX_CNT_HI:   rd_d = cnt_q[15:8];
      `TMRCC_IDX_CNT_LO:   rd_d = cnt_q[7:0];
      `TMRCC_IDX_ACNT_HI:  rd_d = cnt_q[15:8];
      `TMRCC_IDX_ACNT_LO:  rd_d = cnt_q[7:0];
      `TMRCC_IDX_CAPB_HI:  rd_d = capb_q[15:8];
      `TMRCC_IDX_CAPB_LO:  rd_d = capb_q[7:0];
      `TMRCC_IDX_CMPB_HI:  rd_d = cmpb_q[15:8];
      `TMRCC_IDX_CMPB_LO:  rd_d = cmpb_q[7:0];
      default: begin
        rd_d  = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  // axi write channel: take address and data in any order, answer after both
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TMRCC_RESP_OKAY;
      waddr_q   <= 6'h00;
      wbyte_q   <= 8'h00;
      wlane_q   <= 1'b0;
    end else begin
      if (awvalid & awready_q) begin
        awready_q <= 1'b0;
        waddr_q   <= awaddr[7:2];
      end
      if (wvalid & wready_q) begin
        wready_q <= 1'b0;
        wbyte_q  <= wdata[7:0];
        wlane_q  <= wstrb[0];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= (waddr_q < `TMRCC_IDX_CTRL2) ? `TMRCC_RESP_SLVERR : `TMRCC_RESP_OKAY;
      end
      if (bvalid_q & bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // axi read channel: data sampled at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `TMRCC_RESP_OKAY;
      rbyte_q   <= 8'h00;
    end else begin
      if (rd_go) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rbyte_q   <= rd_d;
        rresp_q   <= rd_ok ? `TMRCC_RESP_OKAY : `TMRCC_RESP_SLVERR;
      end else if (rvalid_q & rready) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // software-written registers; only byte lane zero carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_q  <= `TMRCC_CTRL_RST;
      ctrl2_q  <= `TMRCC_CTRL_RST;
      freeze_q <= 1'b0;
      cmpa_q   <= `TMRCC_CMP_RST;
      cmpb_q   <= `TMRCC_CMP_RST;
    end else if (wr_go & wlane_q) begin
      case (waddr_q)
        `TMRCC_IDX_CTRL1:   ctrl1_q <= wbyte_q;
        `TMRCC_IDX_CTRL2:   ctrl2_q <= wbyte_q;
        `TMRCC_IDX_STATUS:  freeze_q <= wbyte_q[`TMRCC_ST_FREEZE];
        `TMRCC_IDX_CMPA_HI: cmpa_q[15:8] <= wbyte_q;
        `TMRCC_IDX_CMPA_LO: cmpa_q[7:0] <= wbyte_q;
        `TMRCC_IDX_CMPB_HI: cmpb_q[15:8] <= wbyte_q;
        `TMRCC_IDX_CMPB_LO: cmpb_q[7:0] <= wbyte_q;
        default: ;
      endcase
    end
  end

  // counter, prescaler, captures and halt arming
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q   <= `TMRCC_CNT_RST;
      presc_q <= 3'h0;
      capa_q  <= `TMRCC_CNT_RST;
      capb_q  <= `TMRCC_CNT_RST;
      armed_q <= 2'b00;
      halt_q  <= 1'b0;
    end else begin
      halt_q <= halt_mode;
      cnt_q  <= cnt_d;
      if (run) begin
        presc_q <= presc_q + 3'h1;
      end
      if (cnt_clear) begin
        presc_q <= 3'h0;
      end
      // edges during halt are remembered, not captured
      if (halt_mode) begin
        armed_q <= armed_q | {capb_edge, capa_edge & ~opm_on & ~pwm_on};
      end else if (halt_exit) begin
        armed_q <= 2'b00;
        if (armed_q[0]) begin
          capa_q <= cnt_q;
        end
        if (armed_q[1]) begin
          capb_q <= cnt_q;
        end
      end else if (run) begin
        if (opm_fire) begin
          capa_q <= `TMRCC_OPM_CAP;
        end else if (capa_edge & ~opm_on & ~pwm_on) begin
          capa_q <= cnt_q;
        end
        if (capb_edge) begin
          capb_q <= cnt_q;
        end
      end
    end
  end

  // flags: a set in the clearing cycle wins
  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 5'b0_0000;
      seen_q <= 5'b0_0000;
    end else begin
      flag_q <= (flag_q & ~(low_acc & seen_q)) | set_v;
      if (rd_go & (ridx == `TMRCC_IDX_STATUS)) begin
        seen_q <= flag_q;
      end else begin
        seen_q <= seen_q & ~low_acc;
      end
    end
  end

  // shared interrupt request from enabled flags
  assign irq_src = (ctrl1_q[`TMRCC_C1_CAP_IE] &
                    (flag_q[`TMRCC_FL_CAPA] | flag_q[`TMRCC_FL_CAPB])) |
                   (ctrl1_q[`TMRCC_C1_CMP_IE] &
                    (flag_q[`TMRCC_FL_CMPA] | flag_q[`TMRCC_FL_CMPB])) |
                   (ctrl1_q[`TMRCC_C1_OVF_IE] & flag_q[`TMRCC_FL_OVF]);

  // pin drive and core requests, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      oe_a_q  <= 1'b0;
      oe_b_q  <= 1'b0;
      irq_q   <= 1'b0;
      wake_q  <= 1'b0;
    end else begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      pin_a_q <= out_a_d;
      pin_b_q <= out_b_d;
      // enables only route the pin; compare logic keeps running
      oe_a_q  <= ctrl2_q[`TMRCC_C2_PIN_A_EN] & ~freeze_q;
      oe_b_q  <= ctrl2_q[`TMRCC_C2_PIN_B_EN] & ~freeze_q;
      irq_q   <= irq_src & ~global_irq_mask;
      wake_q  <= irq_src & ~global_irq_mask & wait_mode;
    end
  end

  // outputs
  assign awready       = awready_q;
  assign wready        = wready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign arready       = arready_q;
  assign rvalid        = rvalid_q;
  assign rresp         = rresp_q;
  assign rdata         = {24'h00_0000, rbyte_q};
  assign compare_a_pin = pin_a_q;
  assign compare_a_oe  = oe_a_q;
  assign compare_b_pin = pin_b_q;
  assign compare_b_oe  = oe_b_q;
  assign timer_irq     = irq_q;
  assign wait_wake     = wake_q;

endmodule
`default_nettype wire

//--- dv/tmrcc_top_sva.sv
// Purpose: port-level checks of the capture/compare timer
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bus figures follow the designer's stated latencies
`timescale 1ns/1ns
`default_nettype none
module tmrcc_top_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus channels
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        bvalid,
  input wire logic        awready,
  input wire logic        wready,
  // pins and core
  input wire logic        compare_a_pin,
  input wire logic        compare_b_pin,
  input wire logic        global_irq_mask,
  input wire logic        wait_mode,
  input wire logic        halt_mode,
  input wire logic        timer_irq,
  input wire logic        wait_wake
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // request and wake lines, both registered from the same term
  a_irq_masked: assert property ($past(global_irq_mask) |-> !timer_irq)
    else $error("timer_irq high one cycle after mask");
  a_wake_in_wait: assert property (wait_wake == (timer_irq && $past(wait_mode)))
    else $error("wait_wake does not track timer_irq in wait");
  // halt: compare pins and timer_irq may not move once the freeze has settled
  a_halt_pins: assert property (halt_mode && $past(halt_mode) && $past(halt_mode, 2)
    |-> $stable(compare_a_pin) && $stable(compare_b_pin))
    else $error("compare pin moved during halt");
  a_halt_irq: assert property (halt_mode && $past(halt_mode) && $past(halt_mode, 2)
    |-> $stable(timer_irq))
    else $error("timer_irq changed during halt");
  // bus answers: one cycle read latency, unmapped low indices refused
  a_read_answer: assert property (arvalid && arready |=> rvalid
    && (rresp == (($past(araddr[7:2]) < 6'h31) ? 2'b10 : 2'b00)))
    else $error("read answer late or wrong response");
  a_rdata_byte: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("read data above bit 7 not zero");
  a_read_busy: assert property (rvalid |-> !arready)
    else $error("arready high with read answer pending");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write ready high with response pending");
  // main scenarios reached
  c_irq: cover property ($rose(timer_irq));
  c_wake: cover property (wait_wake);
  c_refused: cover property (rvalid && rresp == 2'b10);
endmodule
`default_nettype wire

//--- dv/tmrcc_pin_model.sv
// Purpose: far-side pins: capture inputs and an external count clock
// Assumes: levels change just after rising edges of aclk
// Notes:   count clock stands still while ext_run is low
`timescale 1ns/1ns
`default_nettype none
module tmrcc_pin_model (
  // clock and run control
  input  wire logic aclk,
  input  wire logic ext_run,
  // pins toward the timer
  output wire logic ext_count_clock_pin,
  output var  logic capture_a_pin = 1'b0,
  output var  logic capture_b_pin = 1'b0
);
  logic [2:0] div_q = 3'h0;
  // four aclk periods per edge, eight per clock period, slow enough for a three-flop synchroniser
  always @(posedge aclk) begin
    if (ext_run) begin
      div_q <= div_q + 3'h1;
    end
  end
  assign ext_count_clock_pin = div_q[2];
  // capture levels are plain steps; edge choice is the timer's job
  task automatic set_caps(input logic a, input logic b);
    capture_a_pin <= a;
    capture_b_pin <= b;
  endtask
endmodule
`default_nettype wire

//--- dv/tmrcc_top_tb_top.sv
// Purpose: register-level tests of the capture/compare timer
// Assumes: bready and rready held high, requests issued after edges
// Notes:   tick rates are measured as counter deltas over 64 cycles
`timescale 1ns/1ns
`default_nettype none
`include "tmrcc_defs.vh"
module tmrcc_top_tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, ext_run = 1'b0, prev;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, rv, t0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  wstrb = 4'h1;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic        global_irq_mask = 1'b1, wait_mode = 1'b0, halt_mode = 1'b0;
  logic [1:0]  rr, br;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, timer_irq, wait_wake;
  wire         capture_a_pin, capture_b_pin, ext_count_clock_pin;
  wire         compare_a_pin, compare_a_oe, compare_b_pin, compare_b_oe;
  int          n_fail = 0, samples_checked = 0, rises;
  logic [5:0]  rst_ix [4] = '{6'h32, 6'h31, 6'h36, 6'h3e};
  logic [7:0]  rst_v [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
  logic [7:0]  tick_v [5] = '{8'h10, 8'h20, 8'h08, 8'h08, 8'h08};
  logic [5:0]  lo_ix [5] = '{6'h35, 6'h37, 6'h39, 6'h3d, 6'h3f};

  tmrcc_top tmrcc_top_i (.*);
  tmrcc_pin_model tmrcc_pin_model_i (.*);
  always #10 aclk = ~aclk;

  // address and data offered together, each dropped when taken
  task automatic wr(input logic [5:0] ix, input logic [7:0] d);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    br = bresp;
  endtask
  task automatic rd(input logic [5:0] ix);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata[7:0];
    rr = rresp;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // status read arms the clear, low-byte accesses finish it
  task automatic clr_flags;
    rd(`TMRCC_IDX_STATUS);
    foreach (lo_ix[i]) rd(lo_ix[i]);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // a hang must not hide behind a silent run
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset values and refusal of an unmapped word
    foreach (rst_ix[i]) begin
      rd(rst_ix[i]);
      chk("reset value", rv, rst_v[i]);
    end
    rd(6'h10);
    chk("unmapped read", rr, 2'b10);
    wr(6'h10, 8'h55);
    chk("unmapped write", br, 2'b10);
    // forced levels reach the pins only while routed
    wr(`TMRCC_IDX_CTRL2, 8'hc0);
    wr(`TMRCC_IDX_CTRL1, 8'h1d);
    repeat (2) @(posedge aclk);
    chk("forced", {compare_a_oe, compare_a_pin, compare_b_oe, compare_b_pin}, 4'hf);
    wr(`TMRCC_IDX_CTRL2, 8'h00);
    repeat (2) @(posedge aclk);
    chk("released", {compare_a_oe, compare_b_oe}, 2'h0);
    // overflow request: masked, wakes wait, cleared in two steps
    global_irq_mask <= 1'b0;
    wr(`TMRCC_IDX_CTRL1, 8'h20);
    wr(`TMRCC_IDX_CTRL2, 8'h04);
    clr_flags;
    wr(`TMRCC_IDX_CNT_LO, 8'h00);
    repeat (20) @(posedge aclk);
    chk("overflow irq", timer_irq, 1'b1);
    global_irq_mask <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("masked irq", timer_irq, 1'b0);
    global_irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("wait wake", wait_wake, 1'b1);
    wait_mode <= 1'b0;
    rd(`TMRCC_IDX_STATUS);
    rd(`TMRCC_IDX_ACNT_LO);
    rd(`TMRCC_IDX_STATUS);
    chk("flag kept", rv[5], 1'b1);
    rd(`TMRCC_IDX_CNT_LO);
    rd(`TMRCC_IDX_STATUS);
    chk("flag cleared", {rv[5], timer_irq}, 2'h0);
    // tick rate per clock source, both external edges
    ext_run <= 1'b1;
    for (int s = 0; s < 5; s++) begin
      wr(`TMRCC_IDX_CTRL2, {4'h0, (s > 3) ? 2'h3 : 2'(s), 1'b0, s == 4});
      rd(`TMRCC_IDX_CNT_LO);
      t0 = rv;
      repeat (62) @(posedge aclk);
      rd(`TMRCC_IDX_CNT_LO);
      chk("ticks per span", 8'(rv - t0), tick_v[s]);
    end
    ext_run <= 1'b0;
    // each capture pin flags only on its selected edge
    for (int e = 0; e < 2; e++) begin
      tmrcc_pin_model_i.set_caps(e[0], e[0]);
      wr(`TMRCC_IDX_CTRL1, {6'h00, e[0], 1'b0});
      wr(`TMRCC_IDX_CTRL2, {6'h00, e[0], 1'b0});
      clr_flags;
      tmrcc_pin_model_i.set_caps(!e[0], !e[0]);
      repeat (8) @(posedge aclk);
      rd(`TMRCC_IDX_STATUS);
      chk("wrong edge", rv & 8'h90, 8'h00);
      tmrcc_pin_model_i.set_caps(e[0], e[0]);
      repeat (8) @(posedge aclk);
      rd(`TMRCC_IDX_STATUS);
      chk("right edge", rv & 8'h90, 8'h90);
    end
    // halt holds the count; an armed capture lands at exit
    wr(`TMRCC_IDX_CTRL1, 8'h00);
    clr_flags;
    halt_mode <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(`TMRCC_IDX_CNT_LO);
    t0 = rv;
    tmrcc_pin_model_i.set_caps(1'b0, 1'b1);
    repeat (20) @(posedge aclk);
    rd(`TMRCC_IDX_CNT_LO);
    chk("count held", rv, t0);
    halt_mode <= 1'b0;
    repeat (8) @(posedge aclk);
    rd(`TMRCC_IDX_CAPA_LO);
    chk("exit capture", rv, t0);
    rd(`TMRCC_IDX_STATUS);
    chk("wake flag", rv[7], 1'b1);
    // pwm with one-pulse also set: repeating pulse, no compare flags
    wr(`TMRCC_IDX_CMPA_HI, 8'h00);
    wr(`TMRCC_IDX_CMPA_LO, 8'h08);
    wr(`TMRCC_IDX_CMPB_HI, 8'h00);
    wr(`TMRCC_IDX_CMPB_LO, 8'h10);
    wr(`TMRCC_IDX_CTRL1, 8'h04);
    wr(`TMRCC_IDX_CTRL2, 8'hb4);
    wr(`TMRCC_IDX_CNT_LO, 8'h00);
    clr_flags;
    rises = 0;
    prev = 1'b0;
    repeat (200) begin
      @(posedge aclk);
      if (compare_a_pin === 1'b1 && prev === 1'b0) rises++;
      prev = compare_a_pin;
    end
    rd(`TMRCC_IDX_STATUS);
    chk("pwm flags", rv & 8'hc8, 8'h80);
    chk("pwm pulses", 1'(rises >= 3), 1'b1);
    // one-pulse alone, fired by a falling capture a edge
    wr(`TMRCC_IDX_CTRL2, 8'ha4);
    tmrcc_pin_model_i.set_caps(1'b1, 1'b1);
    repeat (8) @(posedge aclk);
    tmrcc_pin_model_i.set_caps(1'b0, 1'b1);
    repeat (8) @(posedge aclk);
    rd(`TMRCC_IDX_CAPA_LO);
    chk("one pulse", {compare_a_pin, rv}, 9'h1fd);
    repeat (30) @(posedge aclk);
    chk("pulse end", compare_a_pin, 1'b0);
    tally_and_finish;
  end
endmodule
bind tmrcc_top tmrcc_top_sva tmrcc_top_sva_i (.*);
`default_nettype wire
